// file: design/drc_controller.sv
// host-side sequencer for a 64K x 1 asynchronous dynamic ram
// assumes the user side is on clk and the ram pins are wired directly
//
// How it works
// - write strobe low before column strobe: early write
// - read-write drops write strobe after read data
// - column strobe never pulses without row strobe
// - write strobe stays high past read strobes
// - row-only refresh holds column strobe high
// - automatic refresh pulse width and cycle bounded
// - row strobe high before refresh pin falls
// - self refresh low long, then exit wait
// - refresh pulse setup before next row strobe
// - page cycles respect cycle and high widths
// - page read-write uses longer page cycle
// - write data set at column fall, held
// - write strobe low width and hold respected
// - read-write data valid at write fall
// - both strobes low after write strobe falls
// - read keeps write strobe high at column fall
// - row strobe and refresh pin never both low
module drc_controller (
	input wire logic clk, // 200 MHz system clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic reqValid, // request offered
	output logic reqReady, // request taken when both high
	input wire drc_pkg::drc_op_t reqOp, // kind of cycle
	input wire logic [drc_pkg::ADDR_W-1:0] reqRow, // row address
	input wire logic [drc_pkg::ADDR_W-1:0] reqCol, // column address
	input wire logic reqData, // bit to write
	input wire logic reqKeepRow, // leave the row open for page mode
	input wire logic selfHold, // stay in self refresh while high
	output logic rdValid, // read bit ready, one-cycle pulse
	output logic rdData, // read bit
	output logic busy, // sequencer not idle
	output logic rasN, // row strobe pin, active low
	output logic casN, // column strobe pin, active low
	output logic weN, // write strobe pin, active low
	output logic refN, // refresh pin, active low
	output logic [drc_pkg::ADDR_W-1:0] addr, // multiplexed address pins
	output logic dOut, // data-in pin of the ram
	input wire logic qIn // data-out pin of the ram
);
	import drc_pkg::*;

	// ****************************************************
	// declarations
	// ****************************************************
	logic rstN; // synchronised reset
	logic qSync; // synchronised data-out
	drc_state_t state_q, stateD; // sequencer state
	logic rasN_q, rasD, casN_q, casD, weN_q, weD, refN_q, refD; // pins
	logic [ADDR_W-1:0] addr_q, addrD; // address pins
	logic dOut_q, dOutD; // data pin
	drc_op_t opQ; // cycle in progress
	logic [ADDR_W-1:0] colQ; // column of the cycle
	logic dataQ; // write bit of the cycle
	logic keepQ; // row stays open afterwards
	logic inPage_q; // current column cycle is a page cycle
	logic [CNT_W-1:0] pgMin_q; // page cycle length owed to last op
	logic [CNT_W-1:0] rasCnt_q; // cycles since row strobe fell
	logic [7:0] casCnt_q; // cycles since column strobe fell
	logic [3:0] wCnt_q; // cycles since write strobe fell
	logic [7:0] hiCnt_q; // cycles row strobe high, for checks
	logic [CNT_W-1:0] refLoCnt_q; // cycles refresh pin low, for checks
	logic [7:0] refHiCnt_q; // cycles refresh pin high, for checks
	logic readDone_q; // read bit taken in this column cycle
	logic rdValid_q, rdData_q; // read result
	logic tLoad, tDone; // wait timer
	logic [CNT_W-1:0] tVal; // wait length
	logic accept; // request taken this cycle
	logic isCol; // offered op is a column cycle
	logic rasGuard; // row open nearly too long
	logic sampleNow; // take the read bit now
	logic colDone; // column cycle may end now

	// ****************************************************
	// synchronisers and timer
	// ****************************************************
	drc_sync2 #(.RESET_VAL(1'b0)) uRstSync (
		.clk(clk),
		.rst_n(reset_n),
		.d(1'b1),
		.q(rstN)
	);

	// data-out is asynchronous to clk, two flops before use
	drc_sync2 #(.RESET_VAL(1'b0)) uQSync (
		.clk(clk),
		.rst_n(rstN),
		.d(qIn),
		.q(qSync)
	);

	drc_delay_timer #(.W(CNT_W)) uWait (
		.clk(clk),
		.rst_n(rstN),
		.load(tLoad),
		.loadVal(tVal),
		.done(tDone)
	);

	// ****************************************************
	// handshake and cycle conditions
	// ****************************************************
	assign isCol = (reqOp == OP_READ) || (reqOp == OP_WRITE) ||
		(reqOp == OP_RDWR);
	assign rasGuard = 32'(rasCnt_q) >= RAS_LOW_MAX_CYC - RAS_GUARD_CYC;
	// page continuation only once the column precharge has run out
	assign reqReady = (state_q == S_IDLE) ||
		(state_q == S_PAGEHI && tDone && isCol && !rasGuard);
	assign accept = reqValid && reqReady;

	// read bit taken only after both access times plus sync delay
	assign sampleNow = (state_q == S_CASLO) && (opQ != OP_WRITE) &&
		!readDone_q && 32'(casCnt_q) >= CAS_ACC_CYC + SYNC_CYC &&
		32'(rasCnt_q) >= RAS_ACC_CYC + SYNC_CYC;

	// each cycle kind ends once its widths and holds are met
	always_comb begin
		colDone = 1'b0;
		if (opQ == OP_READ) begin
			colDone = readDone_q;
		end else if (opQ == OP_WRITE) begin
			colDone = 32'(casCnt_q) >= CAS_LOW_CYC &&
				32'(rasCnt_q) >= RAS_LOW_CYC;
		end else if (opQ == OP_RDWR) begin
			colDone = readDone_q && !weN_q &&
				32'(wCnt_q) >= WE_LOW_CYC &&
				32'(wCnt_q) >= WE_HOLD_CYC;
		end
	end

	// ****************************************************
	// sequencer next state and pin values
	// ****************************************************
	always_comb begin
		stateD = state_q;
		rasD = rasN_q;
		casD = casN_q;
		weD = weN_q;
		refD = refN_q;
		addrD = addr_q;
		dOutD = dOut_q;
		tLoad = 1'b0;
		tVal = '0;
		unique case (state_q)
			S_IDLE: begin
				// row strobe and refresh pin only start from idle
				if (accept) begin
					if (isCol || reqOp == OP_REFROW) begin
						stateD = S_ROW;
						rasD = 1'b0;
						addrD = reqRow;
					end else if (reqOp == OP_REFAUTO) begin
						stateD = S_REFLO;
						refD = 1'b0;
						tLoad = 1'b1;
						tVal = CNT_W'(REF_LO_CYC);
					end else if (reqOp == OP_REFSELF) begin
						stateD = S_SELF;
						refD = 1'b0;
						tLoad = 1'b1;
						tVal = CNT_W'(SELF_LO_CYC);
					end
				end
			end
			S_ROW: begin
				if (opQ == OP_REFROW) begin
					// column strobe stays high for the whole cycle
					if (32'(rasCnt_q) >= RAS_LOW_CYC) begin
						stateD = S_PRE;
						rasD = 1'b1;
						tLoad = 1'b1;
						tVal = CNT_W'(RAS_PRE_CYC);
					end
				end else if (32'(rasCnt_q) >= ROW_HOLD_CYC) begin
					stateD = S_COLADR;
					addrD = colQ;
					dOutD = dataQ;
					weD = (opQ != OP_WRITE);
				end
			end
			S_COLADR: begin
				// page cycles are timed from the previous column fall
				if (inPage_q ? casCnt_q >= 8'(pgMin_q) :
					32'(rasCnt_q) >= RAS_CAS_CYC) begin
					stateD = S_CASLO;
					casD = 1'b0;
				end
			end
			S_CASLO: begin
				if (opQ == OP_RDWR && readDone_q && weN_q) begin
					weD = 1'b0;
				end
				if (colDone) begin
					casD = 1'b1;
					weD = 1'b1;
					tLoad = 1'b1;
					if (keepQ) begin
						stateD = S_PAGEHI;
						tVal = CNT_W'(CAS_PRE_PG_CYC);
					end else begin
						stateD = S_PRE;
						rasD = 1'b1;
						tVal = CNT_W'(RAS_PRE_CYC);
					end
				end
			end
			S_PAGEHI: begin
				if (accept) begin
					stateD = S_COLADR;
					addrD = reqCol;
					dOutD = reqData;
					weD = (reqOp != OP_WRITE);
				end else if (rasGuard || (reqValid && !isCol)) begin
					// close the row; refresh waits for idle
					stateD = S_PRE;
					rasD = 1'b1;
					tLoad = 1'b1;
					tVal = CNT_W'(RAS_PRE_CYC);
				end
			end
			S_PRE: begin
				if (tDone && 32'(rasCnt_q) >= CYCLE_CYC) begin
					stateD = S_IDLE;
				end
			end
			S_REFLO: begin
				if (tDone) begin
					stateD = S_REFREC;
					refD = 1'b1;
					tLoad = 1'b1;
					tVal = CNT_W'(REF_SETUP_CYC);
				end
			end
			S_SELF: begin
				if (tDone && !selfHold) begin
					stateD = S_REFREC;
					refD = 1'b1;
					tLoad = 1'b1;
					tVal = CNT_W'(SELF_EXIT_CYC);
				end
			end
			S_REFREC: begin
				// device steps its own refresh row, no address needed
				if (tDone) begin
					stateD = S_IDLE;
				end
			end
			default: begin
				// illegal code: park the pins safely
				stateD = S_IDLE;
				rasD = 1'b1;
				casD = 1'b1;
				weD = 1'b1;
				refD = 1'b1;
			end
		endcase
	end

	// ****************************************************
	// sequencer and pin registers
	// ****************************************************
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_q <= S_IDLE;
			rasN_q <= 1'b1;
			casN_q <= 1'b1;
			weN_q <= 1'b1;
			refN_q <= 1'b1;
			addr_q <= '0;
			dOut_q <= 1'b0;
		end else begin
			state_q <= stateD;
			rasN_q <= rasD;
			casN_q <= casD;
			weN_q <= weD;
			refN_q <= refD;
			addr_q <= addrD;
			dOut_q <= dOutD;
		end
	end

	// ****************************************************
	// request latch; kind is fixed when taken
	// ****************************************************
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			opQ <= OP_READ;
			colQ <= '0;
			dataQ <= 1'b0;
			keepQ <= 1'b0;
			inPage_q <= 1'b0;
		end else if (accept) begin
			opQ <= reqOp;
			colQ <= reqCol;
			dataQ <= reqData;
			keepQ <= reqKeepRow && isCol;
			inPage_q <= (state_q == S_PAGEHI);
		end
	end

	// page length owed by the column cycle just started
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pgMin_q <= CNT_W'(PG_RD_CYC);
		end else if (!casD && casN_q) begin
			pgMin_q <= (opQ == OP_RDWR) ? CNT_W'(PG_RW_CYC) :
				CNT_W'(PG_RD_CYC);
		end
	end

	// ****************************************************
	// strobe age counters, saturating
	// ****************************************************
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rasCnt_q <= '1;
			casCnt_q <= CNT8_RST;
			wCnt_q <= '1;
		end else begin
			if (!rasD && rasN_q) rasCnt_q <= '0;
			else if (rasCnt_q != '1) rasCnt_q <= rasCnt_q + 1'b1;
			if (!casD && casN_q) casCnt_q <= '0;
			else if (casCnt_q != '1) casCnt_q <= casCnt_q + 1'b1;
			if (!weD && weN_q) wCnt_q <= '0;
			else if (wCnt_q != '1) wCnt_q <= wCnt_q + 1'b1;
		end
	end

	// level widths, read only by the checks below
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			hiCnt_q <= CNT8_RST;
			refHiCnt_q <= CNT8_RST;
			refLoCnt_q <= '0;
		end else begin
			if (!rasN_q) hiCnt_q <= '0;
			else if (hiCnt_q != '1) hiCnt_q <= hiCnt_q + 1'b1;
			if (!refN_q) refHiCnt_q <= '0;
			else if (refHiCnt_q != '1) refHiCnt_q <= refHiCnt_q + 1'b1;
			if (refN_q) refLoCnt_q <= '0;
			else if (refLoCnt_q != '1) refLoCnt_q <= refLoCnt_q + 1'b1;
		end
	end

	// ****************************************************
	// read capture
	// ****************************************************
	// bit is latched once; later hidden refresh cannot disturb it
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			readDone_q <= 1'b0;
			rdValid_q <= 1'b0;
			rdData_q <= 1'b0;
		end else begin
			rdValid_q <= sampleNow;
			if (!casD && casN_q) readDone_q <= 1'b0;
			else if (sampleNow) readDone_q <= 1'b1;
			if (sampleNow) rdData_q <= qSync;
		end
	end

	assign rdValid = rdValid_q;
	assign rdData = rdData_q;
	assign busy = (state_q != S_IDLE);
	assign rasN = rasN_q;
	assign casN = casN_q;
	assign weN = weN_q;
	assign refN = refN_q;
	assign addr = addr_q;
	assign dOut = dOut_q;

	// ****************************************************
	// checks
	// ****************************************************
	earlyWrite_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(casN_q) && opQ == OP_WRITE |-> !weN_q)
		else $error("write strobe not low at column fall");
	readWeHigh_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(casN_q) && opQ == OP_READ |-> weN_q)
		else $error("read with write strobe low");
	rowOnlyCas_a: assert property (@(posedge clk) disable iff (!rstN)
		opQ == OP_REFROW && !rasN_q |-> casN_q)
		else $error("column strobe low in row-only refresh");
	refRasExcl_a: assert property (@(posedge clk) disable iff (!rstN)
		rasN_q || refN_q)
		else $error("row strobe and refresh pin both low");
	rasToRef_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(refN_q) |-> 32'($past(hiCnt_q)) >= RAS_REF_CYC - 1)
		else $error("refresh pin fell too soon after row strobe");
	autoPulse_a: assert property (@(posedge clk) disable iff (!rstN)
		$rose(refN_q) && opQ == OP_REFAUTO |->
		32'($past(refLoCnt_q)) >= REF_LO_CYC - 1 &&
		32'($past(refLoCnt_q)) <= REF_LO_MAX_CYC - 1)
		else $error("automatic refresh pulse width out of range");
	selfPulse_a: assert property (@(posedge clk) disable iff (!rstN)
		$rose(refN_q) && opQ == OP_REFSELF |->
		32'($past(refLoCnt_q)) >= SELF_LO_CYC - 1)
		else $error("self refresh pulse too short");
	refSetup_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(rasN_q) |-> 32'($past(refHiCnt_q)) >= REF_SETUP_CYC - 1)
		else $error("row strobe too soon after refresh pulse");
	pageCycle_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(casN_q) && inPage_q |->
		32'($past(casCnt_q)) >= PG_RD_CYC - 1)
		else $error("page cycle too short");
	casWidth_a: assert property (@(posedge clk) disable iff (!rstN)
		$rose(casN_q) |-> 32'($past(casCnt_q)) >= CAS_LOW_CYC - 1)
		else $error("column strobe low too short");
	wePulse_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(weN_q) |-> !weN_q [*8])
		else $error("write strobe pulse too short");
	strobesAfterWe_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(weN_q) && !casN_q |-> (!casN_q && !rasN_q) [*8])
		else $error("strobe rose too soon after write strobe");
	dataStable_a: assert property (@(posedge clk) disable iff (!rstN)
		$changed(dOut_q) |-> $past(casN_q) && $past(weN_q))
		else $error("write data moved inside write window");
	// column strobe is only ever low inside a row cycle
	casNeedsRas_a: assert property (@(posedge clk) disable iff (!rstN)
		!casN_q |-> !rasN_q)
		else $error("column strobe low without row strobe");
	// a read never lowers the write strobe, so both holds are met
	readWeHold_a: assert property (@(posedge clk) disable iff (!rstN)
		opQ == OP_READ |-> weN_q)
		else $error("write strobe low during a read");
	// page cycle owed by the previous column op, read-write longer
	pageOwed_a: assert property (@(posedge clk) disable iff (!rstN)
		$fell(casN_q) && inPage_q |->
		32'($past(casCnt_q)) >= 32'($past(pgMin_q)) - 1)
		else $error("page cycle shorter than owed");

	rdDone_c: cover property (@(posedge clk) disable iff (!rstN)
		rdValid_q && opQ == OP_READ);
	rdwr_c: cover property (@(posedge clk) disable iff (!rstN)
		$fell(weN_q) && !casN_q);
	page_c: cover property (@(posedge clk) disable iff (!rstN)
		$fell(casN_q) && inPage_q);
	self_c: cover property (@(posedge clk) disable iff (!rstN)
		$rose(refN_q) && opQ == OP_REFSELF);

endmodule

// file: design/drc_delay_timer.sv
// reloadable down-counter that marks the end of a wait
// assumes load is a one-cycle strobe from logic on the same clock
module drc_delay_timer #(
	parameter int W = 11 // counter width
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset, active low
	input wire logic load, // start a new wait
	input wire logic [W-1:0] loadVal, // wait length in cycles
	output logic done // wait over, level
);

	logic [W-1:0] cnt_q; // cycles still to wait

	// ****************************************************
	// count down to zero and stop there
	// ****************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= loadVal;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign done = (cnt_q == '0); // idle timer counts as expired

endmodule

// file: design/drc_sync2.sv
// two-stage synchroniser with a constant reset value
// assumes d may change at any time relative to clk
module drc_sync2 #(
	parameter logic RESET_VAL = 1'b0 // value held during reset
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic d, // asynchronous level in
	output logic q // level in the clk domain
);

	logic meta_q; // first stage, read only by the second

	// ****************************************************
	// two flops in series
	// ****************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

// file: include/drc_pkg.sv
// shared constants and types of the dram cycle controller
// assumes a 200 MHz clock; every figure below is for the faster speed grade
package drc_pkg;

	// ****************************************************
	// clock
	// ****************************************************
	localparam int CLK_NS = 5; // clock period in ns
	localparam int SYNC_CYC = 2; // latency of the data-out synchroniser

	// ****************************************************
	// times in ns, as the device needs them
	// ****************************************************
	localparam int ROW_HOLD_NS = 15; // row address hold after row strobe
	localparam int RAS_CAS_NS = 25; // least row to column strobe delay
	localparam int CAS_ACC_NS = 60; // column strobe access time
	localparam int RAS_ACC_NS = 120; // row strobe access time
	localparam int CAS_LOW_NS = 60; // least column strobe low width
	localparam int RAS_LOW_NS = 120; // least row strobe low width
	localparam int RAS_LOW_MAX_NS = 10000; // longest row strobe low width
	localparam int RAS_PRE_NS = 90; // least row strobe high width
	localparam int CYCLE_NS = 245; // least full cycle, read-write worst
	localparam int WE_LOW_NS = 40; // least write strobe low width
	localparam int WE_HOLD_NS = 40; // strobes low after write strobe falls
	localparam int CAS_PRE_PG_NS = 55; // column strobe high in page mode
	localparam int PG_RD_NS = 140; // page read or write cycle
	localparam int PG_RW_NS = 150; // page read-write cycle
	localparam int RAS_REF_NS = 90; // row strobe high before refresh pin
	localparam int REF_LO_NS = 60; // automatic refresh pulse, least
	localparam int REF_LO_MAX_NS = 8000; // automatic refresh pulse, longest
	localparam int SELF_LO_NS = 8000; // least refresh pin low for self
	localparam int SELF_EXIT_NS = 310; // self refresh exit to row strobe
	localparam int REF_SETUP_NS = 250; // refresh pulse to row strobe

	// ****************************************************
	// times in cycles; least times round up, longest round down
	// ****************************************************
	localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_CAS_CYC = (RAS_CAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAS_ACC_CYC = (CAS_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_ACC_CYC = (RAS_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAS_LOW_CYC = (CAS_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_LOW_CYC = (RAS_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_LOW_MAX_CYC = RAS_LOW_MAX_NS / CLK_NS;
	localparam int RAS_PRE_CYC = (RAS_PRE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WE_HOLD_CYC = (WE_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CAS_PRE_PG_CYC = (CAS_PRE_PG_NS + CLK_NS - 1) / CLK_NS;
	localparam int PG_RD_CYC = (PG_RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PG_RW_CYC = (PG_RW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_REF_CYC = (RAS_REF_NS + CLK_NS - 1) / CLK_NS;
	localparam int REF_LO_CYC = (REF_LO_NS + CLK_NS - 1) / CLK_NS;
	localparam int REF_LO_MAX_CYC = REF_LO_MAX_NS / CLK_NS;
	localparam int SELF_LO_CYC = (SELF_LO_NS + CLK_NS - 1) / CLK_NS;
	localparam int SELF_EXIT_CYC = (SELF_EXIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int REF_SETUP_CYC = (REF_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RAS_GUARD_CYC = 64; // margin kept below longest row low

	// ****************************************************
	// widths and reset values
	// ****************************************************
	localparam int CNT_W = 11; // wide enough for the longest count
	localparam int ADDR_W = 8; // multiplexed address pins
	localparam logic [7:0] CNT8_RST = 8'hff; // helper counters start full

	// ****************************************************
	// types
	// ****************************************************
	typedef enum logic [2:0] {
		OP_READ = 3'h0, // read cycle
		OP_WRITE = 3'h1, // early write cycle
		OP_RDWR = 3'h2, // read-write cycle
		OP_REFROW = 3'h3, // row-strobe-only refresh
		OP_REFAUTO = 3'h4, // one automatic refresh pulse
		OP_REFSELF = 3'h5 // self refresh while selfHold stays high
	} drc_op_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ROW = 4'h1,
		S_COLADR = 4'h3,
		S_CASLO = 4'h2,
		S_PAGEHI = 4'h6,
		S_PRE = 4'h7,
		S_REFLO = 4'h5,
		S_SELF = 4'h4,
		S_REFREC = 4'hc
	} drc_state_t;

endpackage

// file: testbench/dram_cycle_timing_and_refresh_test.sv
// self-checking bench for the dram cycle controller
// assumes the ram model below on the far side
module dram_cycle_timing_and_refresh_test;
	timeunit 1ns;
	timeprecision 100ps;
	import drc_pkg::*;
	logic clk = 0, reset_n = 0, reqValid = 0, reqReady, reqData = 0;
	logic reqKeepRow = 0, selfHold = 0, rdValid, rdData, busy;
	logic rasN, casN, weN, refN, dOut, qIn;
	logic [7:0] reqRow = 0, reqCol = 0, addr;
	drc_op_t reqOp = OP_READ;
	logic expQ[$]; // expected read bits, oldest first
	logic [31:0] seed = 32'h87d0; // random source state
	logic [15:0] a; // cell under test
	logic d; // bit written
	int fails = 0, checks = 0, lowN = 0, lowMax = 0, r0;
	drc_controller uut (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
		.reqReady(reqReady), .reqOp(reqOp), .reqRow(reqRow), .reqCol(reqCol),
		.reqData(reqData), .reqKeepRow(reqKeepRow), .selfHold(selfHold),
		.rdValid(rdValid), .rdData(rdData), .busy(busy), .rasN(rasN),
		.casN(casN), .weN(weN), .refN(refN), .addr(addr), .dOut(dOut),
		.qIn(qIn));
	drc_ram_model ram (.rasN(rasN), .casN(casN), .weN(weN), .refN(refN),
		.addr(addr), .dIn(dOut), .q(qIn));
	initial forever #2.5 clk = ~clk;
	// ****************************************************
	// helpers
	// ****************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// offer at falling edge, hold until taken at a rising edge
	task automatic req(input drc_op_t op, input logic [15:0] ad,
		input logic dt, input logic k);
		int n;
		n = 0;
		@(negedge clk);
		reqValid = 1;
		reqOp = op;
		{reqRow, reqCol} = ad;
		reqData = dt;
		reqKeepRow = k;
		while (reqReady !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) check(8'h0, 8'h1);
		@(negedge clk);
		reqValid = 0;
	endtask
	task automatic waitIdle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 5000) check(8'h0, 8'h1);
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ****************************************************
	// monitors
	// ****************************************************
	// each read pulse takes the oldest note, sampled mid-cycle
	always @(negedge clk) if (rdValid === 1'b1) begin
		if (expQ.size() == 0) check(8'h0, 8'h1);
		else check({7'h0, rdData}, {7'h0, expQ.pop_front()});
	end
	// longest refresh pin low stretch
	always @(posedge clk) begin
		lowN = (refN === 1'b0) ? lowN + 1 : 0;
		if (lowN > lowMax) lowMax = lowN;
	end
	initial begin
		#150000;
		check(8'h0, 8'h1);
		test_done;
	end
	// ****************************************************
	// sequence
	// ****************************************************
	initial begin
		repeat (10) @(negedge clk);
		reset_n = 1;
		repeat (3) @(negedge clk);
		check({4'h0, rasN, casN, weN, refN}, 8'h0f);
		// write then read of the same cell, the read in page on odd passes only
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			a = seed[15:0];
			d = seed[16];
			req(OP_WRITE, a, d, i[0]);
			expQ.push_back(d);
			req(OP_READ, a, 1'b0, 1'b0);
			waitIdle;
		end
		$display("write read done");
		// read-write returns old bit and stores new, second one in page
		expQ.push_back(d);
		req(OP_RDWR, a, ~d, 1'b1);
		expQ.push_back(~d);
		req(OP_RDWR, a, d, 1'b1);
		// row-only refresh closes the open page first
		req(OP_REFROW, a, d, 1'b0);
		waitIdle;
		expQ.push_back(d);
		req(OP_READ, a, 1'b0, 1'b0);
		waitIdle;
		$display("read write done");
		r0 = ram.refRows;
		repeat (3) begin
			req(OP_REFAUTO, 16'h0, 1'b0, 1'b0);
			waitIdle;
		end
		check(8'(ram.refRows - r0), 8'h03);
		selfHold = 1;
		req(OP_REFSELF, 16'h0, 1'b0, 1'b0);
		repeat (1700) @(negedge clk);
		selfHold = 0;
		waitIdle;
		check({7'h0, lowMax >= SELF_LO_CYC}, 8'h01);
		expQ.push_back(d);
		req(OP_READ, a, 1'b0, 1'b0);
		waitIdle;
		check(8'(expQ.size()), 8'h00);
		$display("refresh done");
		test_done;
	end
endmodule

// file: testbench/drc_ram_model.sv
// behavioural 64k x 1 dynamic ram seen from its pins
// assumes strobes come from the controller; data out has no pull
module drc_ram_model (
	input wire logic rasN, // row strobe
	input wire logic casN, // column strobe
	input wire logic weN, // write strobe
	input wire logic refN, // refresh pin
	input wire logic [7:0] addr, // multiplexed address
	input wire logic dIn, // data in
	output logic q // data out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic mem [0:65535]; // cell array
	logic [7:0] row; // latched row, all eight address bits
	logic [7:0] col; // latched column
	logic early; // early write seen at column fall
	time tRas; // row fall time
	int refRows = 0; // internal refresh row counter
	initial q = 1'b0;
	// ****************************************************
	// strobes
	// ****************************************************
	// row-only cycles just latch the row: w, d ignored
	always @(negedge rasN) begin
		row = addr;
		tRas = $time;
	end
	// early write keeps q floating; read waits both accesses
	always @(negedge casN) if (!rasN) begin
		col = addr;
		early = !weN;
		if (early) mem[{row, col}] = dIn;
		else begin
			#60;
			if (tRas + 120 > $time) #(tRas + 120 - $time);
			if (!casN) q = mem[{row, col}]; // held while cas low
		end
	end
	// late write: data already read out, then stored
	always @(negedge weN) if (!rasN && !casN && !early)
		mem[{row, col}] = dIn;
	// float: show inverse so a stale read cannot pass
	always @(posedge casN) #35 q = ~q;
	// refresh counter steps with no setup needed
	always @(posedge refN) if (rasN) refRows++;
endmodule
